// [core/ssr_pkg.sv]
// Package for the card status record block: field layout, fixed values and bus map.
// Assumes a 32-bit Avalon-MM register bus with word addressing in bytes.
package ssr_pkg;
  // Record geometry.
  localparam int SSR_REC_BITS = 512;
  localparam int SSR_REC_WORDS = 16;
  // Field positions (low bit of each field).
  localparam int SSR_LANE_LSB = 510;
  localparam int SSR_SECURE_BIT = 509;
  localparam int SSR_VARIANT_LSB = 480;
  localparam int SSR_PROT_LSB = 448;
  localparam int SSR_SPEED_LSB = 440;
  localparam int SSR_MOVE_LSB = 432;
  localparam int SSR_AU_LSB = 428;
  localparam int SSR_ERSIZE_LSB = 408;
  localparam int SSR_ERTIME_LSB = 402;
  localparam int SSR_EROFF_LSB = 400;
  // Fixed field values.
  localparam logic [1:0] SSR_LANE_ONE = 2'h0;
  localparam logic [1:0] SSR_LANE_FOUR = 2'h2;
  localparam logic [15:0] SSR_VARIANT_MEM = 16'h0000;
  localparam logic [31:0] SSR_PROT_SMALL = 32'h03000000;
  localparam logic [31:0] SSR_PROT_MID = 32'h04000000;
  localparam logic [31:0] SSR_PROT_LARGE = 32'h05000000;
  localparam logic [7:0] SSR_SPEED_CLASS10 = 8'h04;
  localparam logic [7:0] SSR_MOVE_DEFAULT = 8'h02;
  localparam logic [3:0] SSR_AU_4MB = 4'h9;
  localparam logic [3:0] SSR_AU_MAX = 4'h9;
  localparam logic [15:0] SSR_ERSIZE_UNITS = 16'h0200;
  localparam logic [5:0] SSR_ERTIME_SEC = 6'h07;
  localparam logic [1:0] SSR_EROFF_SEC = 2'h2;
  localparam logic [7:0] SSR_CTRL_REV = 8'h04;
  localparam logic [7:0] SSR_IO_REV = 8'h05;
  localparam logic [7:0] SSR_SPEC_REV = 8'h00;
  // Maker content in the low 312 bits; value arbitrary.
  localparam logic [31:0] SSR_MAKER_WORD = 32'h5A5A0001;
  // Register map (byte addresses).
  localparam logic [7:0] SSR_REC_BASE = 8'h00;
  localparam logic [7:0] SSR_CTRL_OFS = 8'h40;
  localparam logic [7:0] SSR_SNAP_OFS = 8'h44;
  localparam logic [7:0] SSR_REV_OFS = 8'h48;
  localparam logic [31:0] SSR_UNMAPPED = 32'h00000000;
  // Control register field positions.
  localparam int SSR_CTL_WIDE_BIT = 0;
  localparam int SSR_CTL_SECURE_BIT = 1;
  localparam int SSR_CTL_CAP_LSB = 2;
  localparam logic [3:0] SSR_CTL_RESET = 4'h0;
  // Capacity models.
  typedef enum logic [1:0] {SSR_CAP_SMALL = 2'h0, SSR_CAP_MID = 2'h1,
                            SSR_CAP_LARGE = 2'h2} ssr_cap_t;
  // Live card state feeding the record.
  typedef struct packed {
    logic four_lane;
    logic secured;
    ssr_cap_t capacity;
  } ssr_state_t;
  // Avalon-MM request.
  typedef struct packed {
    logic read;
    logic write;
    logic [7:0] address;
    logic [31:0] writedata;
  } ssr_avreq_t;
endpackage

// [core/ssr_record_build.sv]
// Builds the 512-bit status record from live card state.
// Assumes the state inputs are stable register outputs in the same clock domain.
`timescale 1ns/1ps
`default_nettype none
module ssr_record_build
  import ssr_pkg::*;
(
  // Live state.
  input wire ssr_pkg::ssr_state_t state_in,
  // Assembled record.
  output logic [511:0] record_out
);
  import ssr_pkg::*;
  ////////////////////////////////////////////////////////////////////////////
  // Protected region size follows the capacity model.
  logic [31:0] prot_size;
  always_comb
  begin
    case (state_in.capacity)
      SSR_CAP_SMALL: prot_size = SSR_PROT_SMALL;
      SSR_CAP_MID: prot_size = SSR_PROT_MID;
      SSR_CAP_LARGE: prot_size = SSR_PROT_LARGE;
      default: prot_size = SSR_PROT_LARGE;
    endcase
  end
  ////////////////////////////////////////////////////////////////////////////
  // Fields are packed high to low; unused gaps stay zero.
  always_comb
  begin
    record_out = '0;
    record_out[SSR_LANE_LSB +: 2] = state_in.four_lane ? SSR_LANE_FOUR : SSR_LANE_ONE;
    record_out[SSR_SECURE_BIT] = state_in.secured;
    record_out[SSR_VARIANT_LSB +: 16] = SSR_VARIANT_MEM;
    record_out[SSR_PROT_LSB +: 32] = prot_size;
    record_out[SSR_SPEED_LSB +: 8] = SSR_SPEED_CLASS10;
    record_out[SSR_MOVE_LSB +: 8] = SSR_MOVE_DEFAULT;
    // The reported unit size never exceeds the SSR_AU_MAX ceiling, whatever the capacity model.
    record_out[SSR_AU_LSB +: 4] = (SSR_AU_4MB > SSR_AU_MAX) ? SSR_AU_MAX : SSR_AU_4MB;
    record_out[SSR_ERSIZE_LSB +: 16] = SSR_ERSIZE_UNITS;
    record_out[SSR_ERTIME_LSB +: 6] = SSR_ERTIME_SEC;
    record_out[SSR_EROFF_LSB +: 2] = SSR_EROFF_SEC;
    // Low 312 bits hold a repeating maker word.
    for (int i = 0; i < 9; i++)
    begin
      record_out[i*32 +: 32] = SSR_MAKER_WORD;
    end
    record_out[311:288] = SSR_MAKER_WORD[23:0];
  end
endmodule
`default_nettype wire

// [core/ssr_status_regs.sv]
// Top of the card status record block: Avalon-MM slave with a snapshot of the record.
// Assumes a single clock, synchronous active-high reset, and a well-behaved bus master.
`timescale 1ns/1ps
`default_nettype none
module ssr_status_regs
  import ssr_pkg::*;
(
  // Clock and reset.
  input wire logic clk_in,
  input wire logic sys_rst_in,
  // Avalon-MM slave.
  input wire logic [7:0] avs_address_in,
  input wire logic avs_read_in,
  input wire logic avs_write_in,
  input wire logic [31:0] avs_writedata_in,
  input wire logic [3:0] avs_byteenable_in,
  output logic [31:0] avs_readdata_out,
  output logic avs_waitrequest_out,
  // Command response strobe from the card transport.
  input wire logic resp_strobe_in,
  // Live state view.
  output logic four_lane_out,
  output logic secured_out
);
  import ssr_pkg::*;
  ////////////////////////////////////////////////////////////////////////////
  // Bus handshake state.
  typedef enum logic [2:0] {
    SSR_IDLE = 3'h1,
    SSR_ACK = 3'h2,
    SSR_DONE = 3'h4
  } ssr_bus_state_t;
  ssr_bus_state_t bus_state; // Current handshake state.
  ssr_bus_state_t next_bus_state; // Next handshake state.
  logic [3:0] ctrl; // Control register: lanes, secure, capacity.
  logic [3:0] next_ctrl; // Next control value.
  logic [511:0] snap; // Record captured at the last response or snapshot write.
  logic [511:0] next_snap; // Next captured record.
  logic [31:0] rdata; // Registered read data.
  logic [31:0] next_rdata; // Next read data.
  logic [511:0] live_record; // Record built from current state.
  ssr_state_t live_state; // Current state in struct form.
  ssr_avreq_t req; // Bundled bus request.
  logic [3:0] word_idx; // Record word selected by the address.
  logic [3:0] bit_lane; // Byte-enable bit for each control byte.
  ////////////////////////////////////////////////////////////////////////////
  // Bundle the request and decode the live state.
  always_comb
  begin
    req.read = avs_read_in;
    req.write = avs_write_in;
    req.address = avs_address_in;
    req.writedata = avs_writedata_in;
    live_state.four_lane = ctrl[SSR_CTL_WIDE_BIT];
    live_state.secured = ctrl[SSR_CTL_SECURE_BIT];
    live_state.capacity = ssr_cap_t'(ctrl[SSR_CTL_CAP_LSB +: 2]);
    word_idx = req.address[5:2];
    bit_lane = avs_byteenable_in;
  end
  // Record assembly from live state.
  ssr_record_build u_build (
    .state_in(live_state),
    .record_out(live_record)
  );
  ////////////////////////////////////////////////////////////////////////////
  // Handshake: a request is answered one cycle after it is seen, then a
  // one-cycle gap lets the master drop its request.
  always_comb
  begin
    next_bus_state = bus_state;
    case (bus_state)
      SSR_IDLE:
      begin
        // Accept a new request.
        if (req.read || req.write)
        begin
          next_bus_state = SSR_ACK;
        end
      end
      SSR_ACK:
      begin
        // Waitrequest is low here; the master completes.
        next_bus_state = SSR_DONE;
      end
      SSR_DONE:
      begin
        // Return to idle for the next request.
        next_bus_state = SSR_IDLE;
      end
      default:
      begin
        next_bus_state = SSR_IDLE;
      end
    endcase
  end
  always_ff @(posedge clk_in)
  begin
    if (sys_rst_in)
    begin
      bus_state <= SSR_IDLE;
    end
    else
    begin
      bus_state <= next_bus_state;
    end
  end
  // Waitrequest stays high except in the answer cycle.
  assign avs_waitrequest_out = (bus_state != SSR_ACK);
  ////////////////////////////////////////////////////////////////////////////
  // Control writes and record snapshot.
  always_comb
  begin
    next_ctrl = ctrl;
    next_snap = snap;
    // The write lands at the edge where waitrequest is sampled low.
    if (bus_state == SSR_ACK && req.write && req.address == SSR_CTRL_OFS && bit_lane[0])
    begin
      next_ctrl = req.writedata[3:0];
    end
    // Freeze the record at the response, or on a software snapshot write.
    if (resp_strobe_in || (bus_state == SSR_ACK && req.write && req.address == SSR_SNAP_OFS))
    begin
      next_snap = live_record;
    end
  end
  always_ff @(posedge clk_in)
  begin
    if (sys_rst_in)
    begin
      ctrl <= SSR_CTL_RESET;
      snap <= '0;
    end
    else
    begin
      ctrl <= next_ctrl;
      snap <= next_snap;
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  // Read data, loaded in the idle cycle so it stands during the answer.
  always_comb
  begin
    next_rdata = rdata;
    if (bus_state == SSR_IDLE && req.read)
    begin
      if (req.address[7:6] == SSR_REC_BASE[7:6])
      begin
        // Word 0 holds bits 511:480.
        next_rdata = snap[(15 - word_idx)*32 +: 32];
      end
      else if (req.address == SSR_CTRL_OFS)
      begin
        next_rdata = {28'h0000000, ctrl};
      end
      else if (req.address == SSR_REV_OFS)
      begin
        next_rdata = {8'h00, SSR_SPEC_REV, SSR_IO_REV, SSR_CTRL_REV};
      end
      else
      begin
        next_rdata = SSR_UNMAPPED;
      end
    end
  end
  always_ff @(posedge clk_in)
  begin
    if (sys_rst_in)
    begin
      rdata <= '0;
    end
    else
    begin
      rdata <= next_rdata;
    end
  end
  assign avs_readdata_out = rdata;
  assign four_lane_out = ctrl[SSR_CTL_WIDE_BIT];
  assign secured_out = ctrl[SSR_CTL_SECURE_BIT];
endmodule
`default_nettype wire

// [tb/ssr_resp_model.sv]
// Stand-in for the card transport: one response strobe after a chosen delay.
// Assumes the clock and reset of the block.
`timescale 1ns/1ps
`default_nettype none
module ssr_resp_model
(
  // Clock, reset and bench request.
  input wire logic clk_in,
  input wire logic sys_rst_in,
  input wire logic fire_in,
  input wire logic [3:0] delay_in,
  // Strobe towards the block.
  output logic strobe_out
);
  logic [4:0] cnt; // Cycles left; zero when idle.
  // Counting down lets the response come promptly or slowly.
  always_ff @(posedge clk_in)
  begin
    if (sys_rst_in)
      cnt <= 5'h00;
    else if (fire_in)
      cnt <= {1'b0, delay_in} + 5'h01;
    else if (cnt != 5'h00)
      cnt <= cnt - 5'h01;
  end
  assign strobe_out = (cnt == 5'h01);
endmodule
`default_nettype wire

// [tb/ssr_status_asserts.sv]
// Checker for the status record block.
// Assumes it is bound to the top module and sees only its ports.
`timescale 1ns/1ps
`default_nettype none
module ssr_status_asserts
  import ssr_pkg::*;
(
  // Clock, reset and bus.
  input wire logic clk_in,
  input wire logic sys_rst_in,
  input wire logic [7:0] avs_address_in,
  input wire logic avs_read_in,
  input wire logic avs_write_in,
  input wire logic [31:0] avs_writedata_in,
  input wire logic [3:0] avs_byteenable_in,
  input wire logic [31:0] avs_readdata_out,
  input wire logic avs_waitrequest_out,
  // Card side.
  input wire logic resp_strobe_in,
  input wire logic four_lane_out,
  input wire logic secured_out
);
  logic wr_ok, rd_ok, take, seen, s_lane, s_sec;
  logic [1:0] cap, s_cap;
  logic [31:0] prot;
  assign wr_ok = avs_write_in && !avs_waitrequest_out;
  assign rd_ok = avs_read_in && !avs_waitrequest_out;
  assign take = resp_strobe_in || (wr_ok && avs_address_in == SSR_SNAP_OFS);
  assign prot = !seen ? 32'h0 : (s_cap == 2'h0) ? 32'h03000000 :
    (s_cap == 2'h1) ? 32'h04000000 : 32'h05000000;
  // Shadow of the control register and of the last snapshot.
  always_ff @(posedge clk_in)
  begin
    if (sys_rst_in)
      {seen, s_lane, s_sec, cap, s_cap} <= '0;
    else
    begin
      if (wr_ok && avs_address_in == SSR_CTRL_OFS && avs_byteenable_in[0])
        cap <= avs_writedata_in[3:2];
      if (take)
        {seen, s_lane, s_sec, s_cap} <= {1'b1, four_lane_out, secured_out, cap};
    end
  end
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (sys_rst_in);
  a_lane_secure: assert property (
    rd_ok && avs_address_in == 8'h00 |-> avs_readdata_out[31:29] == {s_lane, 1'b0, s_sec})
    else $error("lane or secure field wrong");
  a_variant_zero: assert property (
    rd_ok && avs_address_in == 8'h00 |-> avs_readdata_out[28:0] == 29'h0)
    else $error("card variant field not zero");
  a_prot_size: assert property (
    rd_ok && avs_address_in == 8'h04 |-> avs_readdata_out == prot)
    else $error("protected size wrong");
  a_speed_alloc: assert property (
    rd_ok && avs_address_in == 8'h08 |-> avs_readdata_out == (seen ? 32'h04029002 : 32'h0))
    else $error("speed or unit fields wrong");
  a_erase_fields: assert property (
    rd_ok && avs_address_in == 8'h0C |-> avs_readdata_out == (seen ? 32'h001E0000 : 32'h0))
    else $error("erase fields wrong");
  a_unused_zero: assert property (
    rd_ok && avs_address_in inside {8'h10, 8'h14} |-> avs_readdata_out == 32'h0)
    else $error("unused bits not zero");
  a_rev_codes: assert property (
    rd_ok && avs_address_in == SSR_REV_OFS |-> avs_readdata_out[23:0] == 24'h000504)
    else $error("revision codes wrong");
  a_ctrl_follow: assert property (
    wr_ok && avs_address_in == SSR_CTRL_OFS && avs_byteenable_in[0]
    |=> {secured_out, four_lane_out} == $past(avs_writedata_in[1:0]))
    else $error("lane outputs do not follow control write");
  c_strobe: cover property (resp_strobe_in);
  c_large: cover property (rd_ok && avs_address_in == 8'h04 && s_cap == 2'h2);
  c_snap_write: cover property (wr_ok && avs_address_in == SSR_SNAP_OFS);
endmodule
bind ssr_status_regs ssr_status_asserts chk (.clk_in, .sys_rst_in, .avs_address_in,
  .avs_read_in, .avs_write_in, .avs_writedata_in, .avs_byteenable_in, .avs_readdata_out,
  .avs_waitrequest_out, .resp_strobe_in, .four_lane_out, .secured_out);
`default_nettype wire

// [tb/card_status_record_record_tb_top.sv]
// Random self-checking bench for the status record block.
// Assumes the response model as the card transport.
`timescale 1ns/1ps
`default_nettype none
module card_status_record_record_tb_top;
  import ssr_pkg::*;
  logic clk_in = 1'b0;
  logic sys_rst_in = 1'b1;
  logic [7:0] addr = 8'h00;
  logic rd = 1'b0;
  logic wr = 1'b0;
  logic [31:0] wdata = 32'h0;
  logic [3:0] be = 4'hF;
  logic fire = 1'b0;
  logic [3:0] dly = 4'h0;
  logic [31:0] rdata, q, d;
  logic waitreq, strobe, lanes, secure, have;
  logic [3:0] ctl, snap;
  int errors = 0;
  int compares = 0;
  int seed = 90275;
  ssr_status_regs uut (.clk_in(clk_in), .sys_rst_in(sys_rst_in), .avs_address_in(addr),
    .avs_read_in(rd), .avs_write_in(wr), .avs_writedata_in(wdata), .avs_byteenable_in(be),
    .avs_readdata_out(rdata), .avs_waitrequest_out(waitreq), .resp_strobe_in(strobe),
    .four_lane_out(lanes), .secured_out(secure));
  ssr_resp_model partner (.clk_in(clk_in), .sys_rst_in(sys_rst_in), .fire_in(fire),
    .delay_in(dly), .strobe_out(strobe));
  initial forever #10 clk_in = ~clk_in;
  // Expected record word from the control value at capture time.
  function automatic logic [31:0] exp_word(input int i, input logic [3:0] c);
    case (i)
      0: exp_word = {c[0], 1'b0, c[1], 29'h0};
      1: exp_word = (c[3:2] == 2'h0) ? 32'h03000000 : (c[3:2] == 2'h1) ? 32'h04000000 :
        32'h05000000;
      2: exp_word = 32'h04029002;
      3: exp_word = 32'h001E0000;
      4, 5: exp_word = 32'h0;
      // Top of the maker area shares its word with the last unused byte.
      6: exp_word = {8'h00, SSR_MAKER_WORD[23:0]};
      default: exp_word = SSR_MAKER_WORD;
    endcase
    if (!have)
      exp_word = 32'h0;
  endfunction
  // Host view of the erase budget: timeout over unit count, times units, plus offset.
  function automatic logic [31:0] erase_secs(input logic [31:0] t, input logic [31:0] n,
    input logic [31:0] x, input logic [31:0] o);
    erase_secs = (n == 32'h0) ? 32'h0 : t * x / n + o;
  endfunction
  task automatic print_verdict();
    if (errors == 0 && compares > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp)
    begin
      errors++;
      $display("FAIL %s expected %h seen %h", name, exp, seen);
    end
  endtask
  // One bus cycle: hold until waitrequest is seen low, then release.
  // Only the watchdog ends a wait that never completes.
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] v);
    addr <= a;
    wdata <= v;
    rd <= !w;
    wr <= w;
    do
    begin
      @(posedge clk_in);
    end
    while (waitreq !== 1'b0);
    q = rdata;
    rd <= 1'b0;
    wr <= 1'b0;
    @(posedge clk_in);
  endtask
  task automatic read_record();
    logic [31:0] w [16];
    logic [15:0] units;
    for (int i = 0; i < 16; i++)
    begin
      bus(1'b0, 8'(4 * i), 32'h0);
      w[i] = q;
      chk("record word", q, exp_word(i, snap));
    end
    // The host sizes its buffer and erase batches from the fields it read.
    units = {w[2][7:0], w[3][31:24]};
    if (have)
    begin
      chk("unit buffer", 32'h00004000 << (w[2][15:12] - 4'h1), 32'h00400000);
      chk("erase timeout", erase_secs(32'(w[3][23:18]), 32'(units), 32'd1024,
        32'(w[3][17:16])), 32'd16);
    end
  endtask
  initial
  begin
    repeat (4) @(posedge clk_in);
    sys_rst_in <= 1'b0;
    {ctl, snap, have} = '0;
    read_record();
    bus(1'b0, SSR_REV_OFS, 32'h0);
    chk("revision codes", {8'h00, q[23:0]}, 32'h00000504);
    bus(1'b0, 8'h80, 32'h0);
    chk("unmapped read", q, 32'h0);
    for (int k = 0; k < 10; k++)
    begin
      be <= 4'($random(seed));
      d = $random(seed);
      bus(1'b1, SSR_CTRL_OFS, d);
      if (be[0])
        ctl = d[3:0];
      chk("lane outputs", {30'h0, secure, lanes}, {30'h0, ctl[1:0]});
      if (k[0])
        bus(1'b1, SSR_SNAP_OFS, d);
      else
      begin
        dly <= 4'($random(seed));
        fire <= 1'b1;
        @(posedge clk_in);
        fire <= 1'b0;
        for (int n = 0; n < 30 && strobe !== 1'b1; n++)
          @(posedge clk_in);
        @(posedge clk_in);
      end
      {snap, have} = {ctl, 1'b1};
      bus(1'b1, SSR_CTRL_OFS, ~d);
      if (be[0])
        ctl = ~d[3:0];
      bus(1'b1, 8'h04, d);
      read_record();
    end
    print_verdict();
  end
  initial
  begin
    repeat (20000) @(posedge clk_in);
    errors++;
    print_verdict();
  end
endmodule
`default_nettype wire
